// [hw/tkas_auto_scan.sv]
// Purpose: hardware auto scan controller for the touch key unit
// Assumes: converter answers each start with one done pulse, same clock
// Notes: runs with no software help, also while the processor idles
`timescale 1ns/10ps
`default_nettype none
module tkas_auto_scan #(
    parameter int INTERVAL_CYCLES = tkas_pkg::INTERVAL_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output tkas_pkg::tkas_conv_req_t conv_req,
    input wire tkas_pkg::tkas_conv_res_t conv_res,
    output logic irq,
    output logic wake
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] samples_minus_one(input logic [1:0] mode);
        case (mode)
            tkas_pkg::MODE_DOUBLE: samples_minus_one = 2'h1;
            tkas_pkg::MODE_QUAD: samples_minus_one = 2'h3;
            default: samples_minus_one = 2'h0;
        endcase
    endfunction
    function automatic logic [1:0] sample_shift(input logic [1:0] mode);
        case (mode)
            tkas_pkg::MODE_DOUBLE: sample_shift = 2'h1;
            tkas_pkg::MODE_QUAD: sample_shift = 2'h2;
            default: sample_shift = 2'h0;
        endcase
    endfunction
    function automatic logic is_bound(input logic [7:0] addr);
        is_bound = (addr >= tkas_pkg::BOUND_BASE_OFS) && (addr <= tkas_pkg::BOUND_LAST_OFS);
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        tkas_idle,
        tkas_start,
        tkas_wait,
        tkas_check
    } tkas_state_t;
    logic [7:0] scan_ctl_reg;
    logic [7:0] touch_ctl_one_reg;
    logic touch_power_down_reg;
    logic [2:0] violating_channel_reg;
    logic violation_polarity_reg;
    logic touch_irq_flag_reg;
    logic touch_irq_enable_reg;
    logic [9:0] upper_bound_reg [0:7];
    logic [9:0] lower_bound_reg [0:7];
    logic [7:0] rdata_next;
    tkas_state_t state_reg;
    logic [2:0] chan_reg;
    logic [1:0] samp_reg;
    logic [9:0] sum_reg;
    logic [1:0] scan_interval_select;
    logic [1:0] auto_scan_enable;
    logic [2:0] scan_channel_count;
    logic auto_active;
    logic pass_tick;
    logic below;
    logic above;
    logic violation;
    logic flag_clear;
    logic [7:0] bound_idx;
    logic [9:0] sample;

    assign scan_interval_select = scan_ctl_reg[tkas_pkg::INTERVAL_LSB +: 2];
    assign auto_scan_enable = scan_ctl_reg[tkas_pkg::ENABLE_LSB +: 2];
    assign scan_channel_count = scan_ctl_reg[tkas_pkg::CHAN_COUNT_LSB +: 3];
    // hardware owns the unit only with enable nonzero and power-down set
    assign auto_active = (auto_scan_enable != tkas_pkg::MODE_OFF) && touch_power_down_reg;
    assign bound_idx = 8'(reg_addr - tkas_pkg::BOUND_BASE_OFS);
    assign violation = (below || above) && (state_reg == tkas_check);
    assign flag_clear = reg_write && (reg_addr == tkas_pkg::IRQ_FLAG_OFS)
        && !reg_wdata[tkas_pkg::IRQ_BIT];
    // samples narrowed in double and quad mode so that the summed count still fits ten bits
    assign sample = conv_res.count >> sample_shift(auto_scan_enable);

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            scan_ctl_reg <= tkas_pkg::AUTO_SCAN_CONTROL_RST;
            touch_ctl_one_reg <= tkas_pkg::TOUCH_CONTROL_ONE_RST;
            touch_power_down_reg <= tkas_pkg::POWER_DOWN_RST;
            touch_irq_enable_reg <= 1'b0;
        end
        else if (ce && reg_write)
        begin
            case (reg_addr)
                tkas_pkg::AUTO_SCAN_CONTROL_OFS: scan_ctl_reg <= {1'b0, reg_wdata[6:0]};
                tkas_pkg::TOUCH_CONTROL_ONE_OFS:
                begin
                    touch_ctl_one_reg <= reg_wdata;
                    // a write cannot set the start bit while hardware owns the unit
                    if (auto_active)
                        touch_ctl_one_reg[tkas_pkg::START_BIT] <= 1'b0;
                end
                tkas_pkg::TOUCH_CONTROL_TWO_OFS:
                    touch_power_down_reg <= reg_wdata[tkas_pkg::POWER_DOWN_BIT];
                tkas_pkg::IRQ_ENABLE_OFS: touch_irq_enable_reg <= reg_wdata[tkas_pkg::IRQ_BIT];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // boundary bytes
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < tkas_pkg::NUM_CHAN; i++)
            begin
                upper_bound_reg[i] <= tkas_pkg::UPPER_BOUND_RST;
                lower_bound_reg[i] <= tkas_pkg::LOWER_BOUND_RST;
            end
        end
        else if (ce && reg_write && is_bound(reg_addr))
        begin
            case (bound_idx[1:0])
                tkas_pkg::BOUND_UPPER_HIGH: upper_bound_reg[bound_idx[4:2]][9:8] <= reg_wdata[1:0];
                tkas_pkg::BOUND_UPPER_LOW: upper_bound_reg[bound_idx[4:2]][7:0] <= reg_wdata;
                tkas_pkg::BOUND_LOWER_HIGH: lower_bound_reg[bound_idx[4:2]][9:8] <= reg_wdata[1:0];
                default: lower_bound_reg[bound_idx[4:2]][7:0] <= reg_wdata;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_next = 8'h00;
        case (reg_addr)
            tkas_pkg::AUTO_SCAN_CONTROL_OFS: rdata_next = scan_ctl_reg;
            tkas_pkg::TOUCH_CONTROL_ONE_OFS: rdata_next = touch_ctl_one_reg;
            tkas_pkg::TOUCH_CONTROL_TWO_OFS:
                rdata_next[tkas_pkg::POWER_DOWN_BIT] = touch_power_down_reg;
            tkas_pkg::SCAN_RESULT_OFS:
                rdata_next[3:0] = {violation_polarity_reg, violating_channel_reg};
            tkas_pkg::IRQ_FLAG_OFS: rdata_next[tkas_pkg::IRQ_BIT] = touch_irq_flag_reg;
            tkas_pkg::IRQ_ENABLE_OFS: rdata_next[tkas_pkg::IRQ_BIT] = touch_irq_enable_reg;
            default:
                if (is_bound(reg_addr))
                begin
                    case (bound_idx[1:0])
                        tkas_pkg::BOUND_UPPER_HIGH:
                            rdata_next[1:0] = upper_bound_reg[bound_idx[4:2]][9:8];
                        tkas_pkg::BOUND_UPPER_LOW:
                            rdata_next = upper_bound_reg[bound_idx[4:2]][7:0];
                        tkas_pkg::BOUND_LOWER_HIGH:
                            rdata_next[1:0] = lower_bound_reg[bound_idx[4:2]][9:8];
                        default: rdata_next = lower_bound_reg[bound_idx[4:2]][7:0];
                    endcase
                end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (ce)
            reg_rdata <= reg_read ? rdata_next : 8'h00;
    end

    // ----------------------------------------------------------------
    // interval timer and bound compare
    // ----------------------------------------------------------------
    tkas_interval_timer #(
        .BASE_CYCLES(INTERVAL_CYCLES)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .run(auto_active),
        .interval_sel(scan_interval_select),
        .overflow(pass_tick)
    );
    tkas_bound_check u_check (
        .clk(clk),
        .reset(reset),
        .count(sum_reg),
        .lower(lower_bound_reg[chan_reg]),
        .upper(upper_bound_reg[chan_reg]),
        .below(below),
        .above(above)
    );

    // ----------------------------------------------------------------
    // scan sequencer
    // ----------------------------------------------------------------
    // no idle input on purpose: passes never wait for the processor
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= tkas_idle;
            chan_reg <= 3'h0;
            samp_reg <= 2'h0;
            sum_reg <= 10'h000;
        end
        else if (ce)
        begin
            case (state_reg)
                tkas_idle:
                begin
                    if (pass_tick && auto_active)
                    begin
                        state_reg <= tkas_start;
                        chan_reg <= 3'h0;
                        samp_reg <= 2'h0;
                        sum_reg <= 10'h000;
                    end
                end
                tkas_start: state_reg <= tkas_wait;
                tkas_wait:
                begin
                    if (!auto_active)
                        state_reg <= tkas_idle;
                    else if (conv_res.done)
                    begin
                        sum_reg <= 10'(sum_reg + sample);
                        if (samp_reg == samples_minus_one(auto_scan_enable))
                            state_reg <= tkas_check;
                        else
                        begin
                            samp_reg <= 2'(samp_reg + 2'h1);
                            state_reg <= tkas_start;
                        end
                    end
                end
                tkas_check:
                begin
                    samp_reg <= 2'h0;
                    sum_reg <= 10'h000;
                    if (chan_reg == scan_channel_count || !auto_active)
                        state_reg <= tkas_idle;
                    else
                    begin
                        chan_reg <= 3'(chan_reg + 3'h1);
                        state_reg <= tkas_start;
                    end
                end
                default: state_reg <= tkas_idle;
            endcase
        end
    end

    // hardware picks the channel; manual select field plays no part
    assign conv_req.start = (state_reg == tkas_start);
    assign conv_req.channel = chan_reg;
    // ----------------------------------------------------------------
    // flag and result
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            touch_irq_flag_reg <= 1'b0;
            violating_channel_reg <= 3'h0;
            violation_polarity_reg <= 1'b0;
        end
        else if (ce)
        begin
            // a violation in the clearing cycle keeps the flag set
            if (violation)
            begin
                touch_irq_flag_reg <= 1'b1;
                violating_channel_reg <= chan_reg;
                violation_polarity_reg <= above;
            end
            else if (flag_clear)
                touch_irq_flag_reg <= 1'b0;
        end
    end

    assign irq = touch_irq_flag_reg && touch_irq_enable_reg;
    assign wake = irq;
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence sample_taken_s;
        state_reg == tkas_wait && conv_res.done && auto_active && ce;
    endsequence
    sequence more_samples_s;
        samp_reg != samples_minus_one(auto_scan_enable);
    endsequence
    irq_wake_a: assert property (@(posedge clk) disable iff (reset)
        violation && touch_irq_enable_reg && ce && !reg_write |=> irq && wake)
        else $error("interrupt request does not follow flag and enable");
    flag_set_a: assert property (@(posedge clk) disable iff (reset)
        violation && ce |=> touch_irq_flag_reg)
        else $error("violation did not set the flag");
    flag_hold_a: assert property (@(posedge clk) disable iff (reset)
        touch_irq_flag_reg && !flag_clear |=> touch_irq_flag_reg)
        else $error("flag dropped without a clearing write");
    flag_clear_a: assert property (@(posedge clk) disable iff (reset)
        flag_clear && !violation && ce |=> !touch_irq_flag_reg)
        else $error("clearing write left the flag set");
    result_latch_a: assert property (@(posedge clk) disable iff (reset)
        violation && ce |=> violating_channel_reg == $past(chan_reg)
            && violation_polarity_reg == $past(above))
        else $error("channel or polarity not latched");
    channel_range_a: assert property (@(posedge clk) disable iff (reset)
        conv_req.start |-> conv_req.channel <= scan_channel_count)
        else $error("channel beyond selected count started");
    pass_begin_a: assert property (@(posedge clk) disable iff (reset)
        state_reg == tkas_idle && pass_tick && auto_active && ce
            |=> conv_req.start && conv_req.channel == 3'h0)
        else $error("overflow did not start a pass at channel zero");
    repeat_sample_a: assert property (@(posedge clk) disable iff (reset)
        sample_taken_s and more_samples_s |=> conv_req.start && chan_reg == $past(chan_reg))
        else $error("channel not sampled again");
    disabled_quiet_a: assert property (@(posedge clk) disable iff (reset)
        !auto_active && state_reg == tkas_idle |=> !conv_req.start)
        else $error("conversion started with auto mode off");
    start_bit_low_a: assert property (@(posedge clk) disable iff (reset)
        auto_active && reg_write && ce && reg_addr == tkas_pkg::TOUCH_CONTROL_ONE_OFS
            |=> !touch_ctl_one_reg[tkas_pkg::START_BIT])
        else $error("start bit set during auto mode");

endmodule
`default_nettype wire

// [hw/tkas_pkg.sv]
// Purpose: shared constants and carriers for the touch key auto scan block
// Assumes: 25 MHz system clock, byte wide register port
// Notes: all offsets are byte addresses on the plain register port
package tkas_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 10;
    localparam int CHAN_W = 3;
    localparam int NUM_CHAN = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] AUTO_SCAN_CONTROL_OFS = 8'h00;
    localparam logic [7:0] TOUCH_CONTROL_ONE_OFS = 8'h01;
    localparam logic [7:0] TOUCH_CONTROL_TWO_OFS = 8'h02;
    localparam logic [7:0] SCAN_RESULT_OFS = 8'h03;
    localparam logic [7:0] IRQ_FLAG_OFS = 8'h04;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h05;
    // four bytes per channel: upper high, upper low, lower high, lower low
    localparam logic [7:0] BOUND_BASE_OFS = 8'h10;
    localparam logic [7:0] BOUND_LAST_OFS = 8'h2f;
    localparam logic [1:0] BOUND_UPPER_HIGH = 2'h0;
    localparam logic [1:0] BOUND_UPPER_LOW = 2'h1;
    localparam logic [1:0] BOUND_LOWER_HIGH = 2'h2;
    localparam logic [1:0] BOUND_LOWER_LOW = 2'h3;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int INTERVAL_LSB = 5;
    localparam int ENABLE_LSB = 3;
    localparam int CHAN_COUNT_LSB = 0;
    localparam int START_BIT = 7;
    localparam int POWER_DOWN_BIT = 4;
    localparam int POLARITY_BIT = 3;
    localparam int IRQ_BIT = 6;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] AUTO_SCAN_CONTROL_RST = 8'h67;
    localparam logic [7:0] TOUCH_CONTROL_ONE_RST = 8'h4f;
    localparam logic POWER_DOWN_RST = 1'b1;
    localparam logic [9:0] UPPER_BOUND_RST = 10'h3ff;
    localparam logic [9:0] LOWER_BOUND_RST = 10'h000;

    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_DOUBLE = 2'h2;
    localparam logic [1:0] MODE_QUAD = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int INTERVAL_BASE_MS = 30;
    localparam int INTERVAL_BASE_CYCLES = (CLK_HZ / 1000) * INTERVAL_BASE_MS;
    localparam int BASE_CNT_W = 20;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic start;
        logic [2:0] channel;
    } tkas_conv_req_t;

    typedef struct packed {
        logic done;
        logic [9:0] count;
    } tkas_conv_res_t;

endpackage

// [hw/tkas_interval_timer.sv]
// Purpose: interval timer raising one overflow pulse per scan interval
// Assumes: run low holds the timer cleared
// Notes: interval is base period times 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module tkas_interval_timer #(
    parameter int BASE_CYCLES = tkas_pkg::INTERVAL_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] interval_sel,
    output logic overflow
);

    logic [19:0] base_reg;
    logic [3:0] unit_reg;
    logic base_wrap;
    logic [3:0] unit_last;

    assign base_wrap = (base_reg == 20'(BASE_CYCLES - 1));
    // 00 30 ms, 01 60 ms, 10 120 ms, 11 240 ms
    assign unit_last = 4'((4'h1 << interval_sel) - 4'h1);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            base_reg <= 20'h00000;
            unit_reg <= 4'h0;
            overflow <= 1'b0;
        end
        else if (ce)
        begin
            overflow <= 1'b0;
            if (!run)
            begin
                base_reg <= 20'h00000;
                unit_reg <= 4'h0;
            end
            else if (base_wrap)
            begin
                base_reg <= 20'h00000;
                if (unit_reg >= unit_last)
                begin
                    unit_reg <= 4'h0;
                    overflow <= 1'b1;
                end
                else
                begin
                    unit_reg <= 4'(unit_reg + 4'h1);
                end
            end
            else
            begin
                base_reg <= 20'(base_reg + 20'h00001);
            end
        end
    end

    overflow_single_a: assert property (@(posedge clk) disable iff (reset)
        overflow && ce |=> !overflow)
        else $error("overflow lasted more than one cycle");

endmodule
`default_nettype wire

// [hw/tkas_bound_check.sv]
// Purpose: compares one channel count against its two boundaries
// Assumes: bounds are stable while a pass runs
// Notes: an upper bound of 1023 can never be exceeded
`timescale 1ns/10ps
`default_nettype none
module tkas_bound_check (
    input wire logic clk,
    input wire logic reset,
    input wire logic [9:0] count,
    input wire logic [9:0] lower,
    input wire logic [9:0] upper,
    output logic below,
    output logic above
);

    assign below = (count < lower);
    assign above = (count > upper);

    max_upper_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (upper == 10'h3ff) |-> !above)
        else $error("upper check fired with bound at maximum");

endmodule
`default_nettype wire

// [tb/tkas_conv_model.sv]
// Purpose: behavioural touch converter answering the scan sequencer
// Assumes: one done pulse three cycles after each start
// Notes: count shows junk outside the done cycle
`timescale 1ns/10ps
`default_nettype none
module tkas_conv_model (
    input wire logic clk,
    input wire logic reset,
    input wire tkas_pkg::tkas_conv_req_t conv_req,
    output var tkas_pkg::tkas_conv_res_t conv_res
);
    logic busy;
    logic [1:0] dly;
    logic [2:0] ch;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            busy <= 1'b0;
            dly <= 2'h0;
            ch <= 3'h0;
            conv_res <= '0;
        end
        else
        begin
            conv_res.done <= 1'b0;
            conv_res.count <= ~conv_res.count;
            if (conv_req.start)
            begin
                busy <= 1'b1;
                dly <= 2'h2;
                ch <= conv_req.channel;
            end
            else if (busy && dly == 2'h0)
            begin
                busy <= 1'b0;
                conv_res.done <= 1'b1;
                // pins sit pulled up so every channel answers; low bits break shifts
                conv_res.count <= 10'h103 + {4'h0, ch, 3'h0};
            end
            else if (busy)
                dly <= dly - 2'h1;
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench for the auto scan block
// Assumes: converter model answers each start after three cycles
// Notes: base interval shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, reset = 1, ce = 1, reg_write = 0, reg_read = 0, irq, wake;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, d;
    logic [9:0] e0;
    int fail_count = 0, tests_run = 0, q;
    tkas_pkg::tkas_conv_req_t conv_req;
    tkas_pkg::tkas_conv_res_t conv_res;
    always #20 clk = ~clk;
    tkas_auto_scan #(.INTERVAL_CYCLES(20)) i_dut (.clk(clk), .reset(reset), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .conv_req(conv_req),
        .conv_res(conv_res), .irq(irq), .wake(wake));
    tkas_conv_model i_conv (.clk(clk), .reset(reset), .conv_req(conv_req),
        .conv_res(conv_res));
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        rd(8'h00, d);
        chk(d, 8'h67);
        rd(8'h02, d);
        chk(d, 8'h10);
        rd(8'h05, d);
        chk(d, 8'h00);
        rd(8'h11, d);
        chk(d, 8'hff);
        rd(8'h40, d);
        chk(d, 8'h00);
        $display("reset test done");
        begin : scenarios
            for (int m = 1; m < 4; m++)
            begin
                // expected channel 0 sum after per-mode sample shift
                e0 = (m == 1) ? 10'h103 : (m == 2) ? 10'h102 : 10'h100;
                // channel 0 below, channel 1 above, channel 2 exactly at its bound
                wr(8'h12, {6'h0, e0[9:8]});
                wr(8'h13, e0[7:0] + 8'h01);
                wr(8'h14, {6'h0, e0[9:8]});
                wr(8'h15, e0[7:0] + 8'h07);
                wr(8'h18, {6'h0, e0[9:8]});
                wr(8'h19, e0[7:0] + 8'h10);
                wr(8'h05, 8'h40);
                // frozen clock enable must swallow this write
                ce <= 1'b0;
                wr(8'h05, 8'h00);
                ce <= 1'b1;
                // interval code follows the mode so passes never run back to back
                wr(8'h00, {1'b0, m[1:0], m[1:0], 3'h2});
                for (int n = 0; n < 2000 && irq !== 1'b1; n++)
                    @(posedge clk);
                chk({6'h0, irq, wake}, 8'h03);
                // wait out the pass: no start for longer than any gap inside it
                q = 0;
                for (int n = 0; n < 400 && q < 12; n++)
                begin
                    @(posedge clk);
                    q = conv_req.start ? 0 : q + 1;
                end
                chk(q[7:0], 8'h0c);
                if (irq !== 1'b1 || q < 12)
                    disable scenarios;
                wr(8'h00, 8'h02);
                rd(8'h03, d);
                chk(d, 8'h09);
                rd(8'h04, d);
                chk(d, 8'h40);
                wr(8'h04, 8'h00);
                rd(8'h04, d);
                chk(d, 8'h00);
                $display("mode %0d test done", m);
            end
        end
        test_done;
    end
endmodule
`default_nettype wire
